/* File: hw/port_input_select_readback.sv */
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - clock source select 0 routes phy clock line, 1 routes pin c6
// - data source select 0 routes phy data line, 1 routes pin c7
// - uart receive source clear selects pin b4; set value reserved
// - upper five input source bits always read zero
// - writing 11001010 to unlock register turns read-back on
// - writing any other byte turns read-back off
// - read-back on returns raw pin levels for every function
// - read-back touches the read path and the selected converter switch, never pin drive or function
// - read-back off, digital output pin reads 0 if input, latch if output
// - serial bus, sim and uart pins always read the pin level
// - read-back off, analog switch only on when analog function selected
// - read-back on forces the selected converter channel switch on
// - reset sets port data and direction registers to all ones
// - bit set and clear read whole port, modify one bit, write back
// - in sleep, falling edge on wake-enabled port pin wakes device
// - unlock register resets to zero so read-back starts disabled
// - phy line supply select upper bit picks main or auxiliary supply
module port_input_select_readback
   import port_sel_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [7:0]  port_pin_in,
   output logic      [7:0]  port_pin_out,
   output logic      [7:0]  port_pin_oe_n,
   input  wire logic        pin_c6,
   input  wire logic        pin_c7,
   input  wire logic        pin_b4,
   input  wire logic        phy_clock_line,
   input  wire logic        phy_data_line,
   input  wire logic        sleep_mode,
   output logic             master_bus_clock_line,
   output logic             master_bus_data_line,
   output logic             uart_rx_in,
   output logic      [1:0]  phy_line_cfg_hi,
   output logic      [1:0]  phy_line_cfg_lo,
   output logic      [1:0]  phy_line_supply_sel,
   output logic             readback_enable,
   output logic      [10:0] analog_switch_on,
   output logic             wake_req
);

   // ==========================================================
   // state
   // ==========================================================
   logic [3:0]  phy_line_config_r;
   logic [2:0]  input_source_select_r;
   logic [7:0]  readback_unlock_r;
   logic [7:0]  port_data_r;
   logic [7:0]  port_dir_r;
   logic [3:0]  supply_r;
   logic [7:0]  wake_en_r;
   logic [15:0] func_r;
   logic [10:0] ana_fn_r;
   logic [3:0]  adc_ch_r;
   logic [7:0]  pin_prev_r;
   logic        readback_enable_r;
   logic        wake_req_r;
   logic        wb_ack_r;
   logic [31:0] wb_dat_r;
   logic [7:0]  digout_mask;
   logic [7:0]  serial_mask;
   logic [7:0]  analog_mask;
   logic [7:0]  port_rd_val;
   logic [7:0]  bitop_base;
   logic [7:0]  bitop_nxt;
   logic [7:0]  wake_fall;
   logic [31:0] rd_mux;
   logic        bus_req;
   logic        wr_hit;

   // ==========================================================
   // wishbone decode
   // ==========================================================
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
   assign wr_hit  = bus_req && wb_we_i && wb_sel_i[0] && clk_en;

   // per-pin function masks
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         digout_mask[i] = (func_r[2*i +: 2] == FN_DIGOUT);
         serial_mask[i] = (func_r[2*i +: 2] == FN_SERIAL);
         analog_mask[i] = (func_r[2*i +: 2] == FN_ANALOG);
      end
   end

   // port read path as seen by a port read instruction
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (serial_mask[i]) begin
            port_rd_val[i] = port_pin_in[i];
         end else if (readback_enable_r) begin
            port_rd_val[i] = port_pin_in[i];
         end else if (analog_mask[i]) begin
            port_rd_val[i] = 1'b0;
         end else if (digout_mask[i]) begin
            port_rd_val[i] = port_dir_r[i] ? 1'b0 : port_data_r[i];
         end else begin
            port_rd_val[i] = port_dir_r[i] ? port_pin_in[i]
                                           : port_data_r[i];
         end
      end
   end

   // bit set/clear: read whole port, change one bit, write back
   always_comb begin
      bitop_base = wb_dat_i[BITOP_DIR] ? port_dir_r : port_rd_val;
      bitop_nxt  = bitop_base;
      bitop_nxt[wb_dat_i[2:0]] = wb_dat_i[BITOP_SET];
   end

   // register read multiplexer, unmapped reads give zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         OFS_PHY_CFG: rd_mux[3:0]  = phy_line_config_r;
         OFS_IN_SRC:  rd_mux[2:0]  = input_source_select_r;
         OFS_UNLOCK:  rd_mux[7:0]  = readback_unlock_r;
         OFS_PDATA:   rd_mux[7:0]  = port_data_r;
         OFS_PDIR:    rd_mux[7:0]  = port_dir_r;
         OFS_PREAD:   rd_mux[7:0]  = port_rd_val;
         OFS_SUPPLY:  rd_mux[3:0]  = supply_r;
         OFS_WAKE_EN: rd_mux[7:0]  = wake_en_r;
         OFS_FUNC:    rd_mux[15:0] = func_r;
         OFS_ANA_FN:  rd_mux[10:0] = ana_fn_r;
         OFS_ADC_CH:  rd_mux[3:0]  = adc_ch_r;
         OFS_STATUS:  rd_mux[1:0]  = {wake_req_r, readback_enable_r};
         default:     rd_mux       = 32'h0000_0000;
      endcase
   end

   // single-cycle ack, read data captured on the same edge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end else if (clk_en) begin
         wb_ack_r <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_r <= rd_mux;
         end
      end
   end

   // ==========================================================
   // configuration registers
   // ==========================================================
   // phy line config, source select, supply select, wake enable, converter channel (low byte only)
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         phy_line_config_r     <= 4'h0;
         input_source_select_r <= 3'h0;
         supply_r              <= 4'h0;
         wake_en_r             <= RST_ZERO8;
         adc_ch_r              <= 4'h0;
      end else if (wr_hit) begin
         case (wb_adr_i)
            OFS_PHY_CFG: phy_line_config_r     <= wb_dat_i[3:0];
            OFS_IN_SRC:  input_source_select_r <= wb_dat_i[2:0];
            OFS_SUPPLY:  supply_r              <= wb_dat_i[3:0];
            OFS_WAKE_EN: wake_en_r             <= wb_dat_i[7:0];
            OFS_ADC_CH:  adc_ch_r              <= wb_dat_i[3:0];
            default:     ;
         endcase
      end
   end

   // pin function and analog function selects
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         func_r   <= RST_FUNC;
         ana_fn_r <= RST_ANA;
      end else if (bus_req && wb_we_i && clk_en) begin
         if (wb_adr_i == OFS_FUNC) begin
            if (wb_sel_i[0]) func_r[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1]) func_r[15:8] <= wb_dat_i[15:8];
         end
         if (wb_adr_i == OFS_ANA_FN) begin
            if (wb_sel_i[0]) ana_fn_r[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ana_fn_r[10:8] <= wb_dat_i[10:8];
         end
      end
   end

   // unlock register and read-back enable, same edge as the write
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         readback_unlock_r <= RST_ZERO8;
         readback_enable_r <= 1'b0;
      end else if (wr_hit && wb_adr_i == OFS_UNLOCK) begin
         readback_unlock_r <= wb_dat_i[7:0];
         readback_enable_r <= (wb_dat_i[7:0] == UNLOCK_PAT);
      end
   end

   // port data and direction, all ones after reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_data_r <= RST_PORT;
         port_dir_r  <= RST_PORT;
      end else if (wr_hit) begin
         case (wb_adr_i)
            OFS_PDATA: port_data_r <= wb_dat_i[7:0];
            OFS_PDIR:  port_dir_r  <= wb_dat_i[7:0];
            OFS_BIT_OP: begin
               if (wb_dat_i[BITOP_DIR]) begin
                  port_dir_r  <= bitop_nxt;
               end else begin
                  port_data_r <= bitop_nxt;
               end
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // pin side outputs
   // ==========================================================
   assign wake_fall = wake_en_r & pin_prev_r & ~port_pin_in;

   // wake request, set wins while asleep, drops on leaving sleep
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_prev_r <= RST_PORT;
         wake_req_r <= 1'b0;
      end else if (clk_en) begin
         pin_prev_r <= port_pin_in;
         if (sleep_mode && (|wake_fall)) begin
            wake_req_r <= 1'b1;
         end else if (!sleep_mode) begin
            wake_req_r <= 1'b0;
         end
      end
   end

   // source routing, drive and analog switches, registered
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         master_bus_clock_line <= 1'b0;
         master_bus_data_line  <= 1'b0;
         uart_rx_in            <= 1'b1;
         port_pin_out          <= RST_PORT;
         port_pin_oe_n         <= RST_PORT;
         analog_switch_on      <= RST_ANA;
      end else if (clk_en) begin
         master_bus_clock_line <= input_source_select_r[IN_SRC_CLK] ?
                                  pin_c6 : phy_clock_line;
         master_bus_data_line  <= input_source_select_r[IN_SRC_DAT] ?
                                  pin_c7 : phy_data_line;
         uart_rx_in            <= pin_b4;
         port_pin_out          <= port_data_r;
         port_pin_oe_n         <= port_dir_r;
         for (int c = 0; c < NUM_ANA; c++) begin
            analog_switch_on[c] <= ana_fn_r[c] ||
               (readback_enable_r && adc_ch_r == 4'(c));
         end
      end
   end

   assign wb_ack_o            = wb_ack_r;
   assign wb_dat_o            = wb_dat_r;
   assign readback_enable     = readback_enable_r;
   assign wake_req            = wake_req_r;
   assign phy_line_cfg_hi     = phy_line_config_r[3:2];
   assign phy_line_cfg_lo     = phy_line_config_r[1:0];
   assign phy_line_supply_sel = supply_r[SUPPLY_HI -: 2];

   // ==========================================================
   // assertions
   // ==========================================================
   unlock_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr_hit && wb_adr_i == OFS_UNLOCK && wb_dat_i[7:0] == UNLOCK_PAT)
      |=> readback_enable) else $error("unlock pattern missed");
   unlock_clr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr_hit && wb_adr_i == OFS_UNLOCK && wb_dat_i[7:0] != UNLOCK_PAT)
      |=> !readback_enable) else $error("read-back stuck on");
   src_upper_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wb_ack_r && $past(wb_adr_i) == OFS_IN_SRC && !$past(wb_we_i))
      |-> wb_dat_o[31:3] == 29'h0) else $error("source bits nonzero");
   clk_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reset_n && clk_en) |=> master_bus_clock_line == $past(
         input_source_select_r[IN_SRC_CLK] ? pin_c6 : phy_clock_line))
      else $error("clock source wrong");
   dat_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reset_n && clk_en) |=> master_bus_data_line == $past(
         input_source_select_r[IN_SRC_DAT] ? pin_c7 : phy_data_line))
      else $error("data source wrong");
   rx_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reset_n && clk_en) |=> uart_rx_in == $past(pin_b4))
      else $error("uart source wrong");
   rb_pins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      readback_enable_r |-> port_rd_val == port_pin_in)
      else $error("read-back not raw pins");
   digout_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !readback_enable_r |-> (port_rd_val & digout_mask & port_dir_r) == 8'h00)
      else $error("digital output input read");
   serial_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      ((port_rd_val ^ port_pin_in) & serial_mask) == 8'h00)
      else $error("serial pin not raw");
   drive_kept_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en |=> port_pin_oe_n == $past(port_dir_r))
      else $error("pin drive disturbed");
   ana_force_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && readback_enable_r && adc_ch_r < 4'hB)
      |=> analog_switch_on[$past(adc_ch_r)])
      else $error("analog path not forced");
   wake_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && sleep_mode && |wake_fall) |=> wake_req)
      else $error("wake missed");
endmodule

/* File: hw/port_sel_pkg.sv */
// ==========================================================
// register map, reset values and field codes
// ==========================================================
package port_sel_pkg;
   // byte offsets on the wishbone slave
   localparam logic [7:0] OFS_PHY_CFG  = 8'h00;
   localparam logic [7:0] OFS_IN_SRC   = 8'h04;
   localparam logic [7:0] OFS_UNLOCK   = 8'h08;
   localparam logic [7:0] OFS_PDATA    = 8'h0C;
   localparam logic [7:0] OFS_PDIR     = 8'h10;
   localparam logic [7:0] OFS_PREAD    = 8'h14;
   localparam logic [7:0] OFS_SUPPLY   = 8'h18;
   localparam logic [7:0] OFS_WAKE_EN  = 8'h1C;
   localparam logic [7:0] OFS_FUNC     = 8'h20;
   localparam logic [7:0] OFS_ANA_FN   = 8'h24;
   localparam logic [7:0] OFS_ADC_CH   = 8'h28;
   localparam logic [7:0] OFS_STATUS   = 8'h2C;
   localparam logic [7:0] OFS_BIT_OP   = 8'h30;

   // reset values
   localparam logic [7:0]  RST_PORT     = 8'hFF;
   localparam logic [7:0]  RST_ZERO8    = 8'h00;
   localparam logic [15:0] RST_FUNC     = 16'h0000;
   localparam logic [10:0] RST_ANA      = 11'h000;

   // read-back unlock pattern 11001010
   localparam logic [7:0] UNLOCK_PAT = 8'hCA;

   // field positions
   localparam int IN_SRC_CLK = 2;
   localparam int IN_SRC_DAT = 1;
   localparam int IN_SRC_RX  = 0;
   localparam int BITOP_SET  = 4;
   localparam int BITOP_DIR  = 3;
   localparam int SUPPLY_HI  = 3;
   localparam int NUM_ANA    = 11;

   // per-pin function codes
   typedef enum logic [1:0] {
      FN_GPIO   = 2'h0,
      FN_DIGOUT = 2'h1,
      FN_SERIAL = 2'h2,
      FN_ANALOG = 2'h3
   } pin_fn_t;
endpackage

/* File: test/pin_far_side.sv */
`timescale 1ns/1ps
// ==========================================================
// pins and phy lines seen from outside the block
// ==========================================================
module pin_far_side (
   input  wire logic [7:0] port_pin_out,
   input  wire logic [7:0] port_pin_oe_n,
   input  wire logic [7:0] ext_level,
   input  wire logic [4:0] ext_misc,
   output logic      [7:0] port_pin_in,
   output logic            pin_c6,
   output logic            pin_c7,
   output logic            pin_b4,
   output logic            phy_clock_line,
   output logic            phy_data_line
);
   // driven pins carry the latch, released pins the outside level
   assign port_pin_in = (port_pin_oe_n & ext_level)
                      | (~port_pin_oe_n & port_pin_out);
   // side lines come straight from the outside world
   assign pin_c6         = ext_misc[0];
   assign pin_c7         = ext_misc[1];
   assign pin_b4         = ext_misc[2];
   assign phy_clock_line = ext_misc[3];
   assign phy_data_line  = ext_misc[4];
endmodule

/* File: test/port_input_select_readback_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench
// ==========================================================
module port_input_select_readback_bench;
   import port_sel_pkg::*;
   logic        core_clk, reset_n, clk_en, sleep_mode;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, port_pin_in, port_pin_out, port_pin_oe_n;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic        pin_c6, pin_c7, pin_b4, phy_clock_line, phy_data_line;
   logic        master_bus_clock_line, master_bus_data_line, uart_rx_in;
   logic [1:0]  phy_line_cfg_hi, phy_line_cfg_lo, phy_line_supply_sel;
   logic        readback_enable, wake_req, rb;
   logic [10:0] analog_switch_on, ana;
   logic [7:0]  ext_level, rnd, dirv, lat, pv;
   logic [4:0]  ext_misc;
   logic [15:0] fn;
   logic [3:0]  ch;
   int          fails, compares;

   port_input_select_readback dut_u (.core_clk(core_clk),
      .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .port_pin_in(port_pin_in),
      .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
      .pin_c6(pin_c6), .pin_c7(pin_c7), .pin_b4(pin_b4),
      .phy_clock_line(phy_clock_line), .phy_data_line(phy_data_line),
      .sleep_mode(sleep_mode),
      .master_bus_clock_line(master_bus_clock_line),
      .master_bus_data_line(master_bus_data_line),
      .uart_rx_in(uart_rx_in), .phy_line_cfg_hi(phy_line_cfg_hi),
      .phy_line_cfg_lo(phy_line_cfg_lo),
      .phy_line_supply_sel(phy_line_supply_sel),
      .readback_enable(readback_enable),
      .analog_switch_on(analog_switch_on), .wake_req(wake_req));
   pin_far_side far_u (.port_pin_out(port_pin_out),
      .port_pin_oe_n(port_pin_oe_n), .ext_level(ext_level),
      .ext_misc(ext_misc), .port_pin_in(port_pin_in), .pin_c6(pin_c6),
      .pin_c7(pin_c7), .pin_b4(pin_b4), .phy_clock_line(phy_clock_line),
      .phy_data_line(phy_data_line));

   // clock generation
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // random source
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   // expected port read value
   function automatic logic [7:0] exp_port(input logic [15:0] f,
      input logic [7:0] d, input logic [7:0] l, input logic [7:0] e,
      input logic r);
      logic [7:0] p;
      logic [7:0] o;
      p = (d & e) | (~d & l);
      for (int i = 0; i < 8; i++) begin
         case (f[2*i +: 2])
            FN_SERIAL: o[i] = p[i];
            FN_ANALOG: o[i] = 1'b0;
            FN_DIGOUT: o[i] = d[i] ? 1'b0 : l[i];
            default:   o[i] = d[i] ? p[i] : l[i];
         endcase
         if (r) o[i] = p[i];
      end
      return o;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // one classic wishbone cycle, held until ack
   task automatic bus(input logic we, input logic [7:0] adr,
      input logic [31:0] d, input logic [3:0] sel);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wb_sel_i <= sel;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      bus(1'b1, adr, d, 4'hF);
   endtask

   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0, 4'hF);
      chk(q, exp);
   endtask

   task automatic stop_test;
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      stop_test;
   end

   // main sequence
   initial begin
      fails = 0; compares = 0; rnd = 8'h39;
      reset_n = 1'b0; clk_en = 1'b1; sleep_mode = 1'b0;
      wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
      wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
      ext_level = 8'hFF; ext_misc = 5'h00;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      chk(port_pin_oe_n, 8'hFF);
      chk(readback_enable, 1'b0);
      rdc(OFS_PDATA, 32'hFF);
      rdc(OFS_PDIR, 32'hFF);
      rdc(OFS_UNLOCK, 32'h0);
      rdc(8'hFC, 32'h0);
      // source routing, bit zero kept clear by software
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         ext_misc <= rnd[4:0];
         wr(OFS_IN_SRC, {rnd[7:3], i[1:0], 1'b0});
         repeat (3) @(posedge core_clk);
         rdc(OFS_IN_SRC, {29'h0, i[1:0], 1'b0});
         chk(master_bus_clock_line, i[1] ? rnd[0] : rnd[3]);
         chk(master_bus_data_line, i[0] ? rnd[1] : rnd[4]);
         chk(uart_rx_in, rnd[2]);
      end
      // clock enable low freezes the routed uart receive line
      clk_en <= 1'b0;
      ext_misc <= ~rnd[4:0];
      repeat (3) @(posedge core_clk);
      chk(uart_rx_in, rnd[2]);
      clk_en <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk(uart_rx_in, !rnd[2]);
      // phy line fields, both settings software may use
      for (int i = 0; i < 2; i++) begin
         wr(OFS_PHY_CFG, i ? 32'h0 : 32'h5);
         chk({phy_line_cfg_hi, phy_line_cfg_lo}, i ? 4'h0 : 4'h5);
      end
      wr(OFS_SUPPLY, {28'h0, rnd[3:0]});
      chk(phy_line_supply_sel, rnd[3:2]);
      // unlock with byte lane zero off must not enable
      bus(1'b1, OFS_UNLOCK, {24'h0, UNLOCK_PAT}, 4'hE);
      chk(readback_enable, 1'b0);
      // random port setups with read-back toggled
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd); dirv = rnd;
         rnd = lfsr(rnd); lat = rnd;
         rnd = lfsr(rnd); fn[7:0] = rnd;
         rnd = lfsr(rnd); fn[15:8] = rnd;
         rnd = lfsr(rnd); ext_level <= rnd;
         rb = k[0];
         wr(OFS_PDATA, {24'h0, lat});
         wr(OFS_PDIR, {24'h0, dirv});
         wr(OFS_FUNC, {16'h0, fn});
         rnd = lfsr(rnd);
         if (rnd == UNLOCK_PAT) rnd = 8'h4A;
         wr(OFS_UNLOCK, {24'h0, rb ? UNLOCK_PAT : rnd});
         chk(readback_enable, rb);
         repeat (3) @(posedge core_clk);
         chk({port_pin_oe_n, port_pin_out}, {dirv, lat});
         pv = exp_port(fn, dirv, lat, ext_level, rb);
         rdc(OFS_PREAD, {24'h0, pv});
         rnd = lfsr(rnd); ana = {rnd[2:0], lfsr(rnd)};
         ch = rnd[7:4];
         wr(OFS_ANA_FN, {21'h0, ana});
         wr(OFS_ADC_CH, {28'h0, ch});
         chk(analog_switch_on, ana | ((rb && ch < 4'hB) ?
            (11'h001 << ch) : 11'h000));
         // single bit operations on data then direction
         lat = pv;
         lat[rnd[2:0]] = rnd[3];
         wr(OFS_BIT_OP, {27'h0, rnd[3], 1'b0, rnd[2:0]});
         rdc(OFS_PDATA, {24'h0, lat});
         dirv[rnd[6:4]] = rnd[7];
         wr(OFS_BIT_OP, {27'h0, rnd[7], 1'b1, rnd[6:4]});
         rdc(OFS_PDIR, {24'h0, dirv});
      end
      // wake from sleep on an enabled falling pin only
      wr(OFS_PDIR, 32'hFF);
      wr(OFS_FUNC, 32'h0);
      wr(OFS_WAKE_EN, 32'h04);
      ext_level <= 8'hFF;
      sleep_mode <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_level <= 8'hDF;
      repeat (4) @(posedge core_clk);
      chk(wake_req, 1'b0);
      ext_level <= 8'hDB;
      for (int n = 0; n < 8 && wake_req !== 1'b1; n++) @(posedge core_clk);
      chk(wake_req, 1'b1);
      rdc(OFS_STATUS, 32'h3);
      sleep_mode <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(wake_req, 1'b0);
      // reset again in mid-run, registers go back to their start values
      wr(OFS_PDATA, 32'h0);
      wr(OFS_PDIR, 32'h0);
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(readback_enable, 1'b0);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rdc(OFS_PDATA, 32'hFF);
      rdc(OFS_PDIR, 32'hFF);
      rdc(OFS_UNLOCK, 32'h0);
      chk(port_pin_oe_n, 8'hFF);
      stop_test;
   end
endmodule
